// ==== vq_ctl_pkg.sv ====
// constants shared by the notification and init-status block
// assumes a 32-bit AXI4-Lite register bus with byte addresses
package vq_ctl_pkg;
  localparam int          ADDR_W       = 8;
  // register byte offsets
  localparam logic [7:0]  OFF_STATUS   = 8'h00;
  localparam logic [7:0]  OFF_DEV_FEAT = 8'h04;
  localparam logic [7:0]  OFF_DRV_FEAT = 8'h08;
  localparam logic [7:0]  OFF_CTRL     = 8'h0c;
  localparam logic [7:0]  OFF_NOTIFY   = 8'h10;
  localparam logic [7:0]  OFF_CFG      = 8'h14;
  localparam logic [7:0]  OFF_SHM      = 8'h18;
  localparam logic [7:0]  OFF_EXPORT   = 8'h1c;
  localparam logic [7:0]  OFF_UUID0    = 8'h20;
  localparam logic [7:0]  OFF_UUID1    = 8'h24;
  localparam logic [7:0]  OFF_UUID2    = 8'h28;
  localparam logic [7:0]  OFF_UUID3    = 8'h2c;
  localparam logic [7:0]  OFF_DROPS    = 8'h30;
  // status bits
  localparam int          ST_ACK       = 0;
  localparam int          ST_DRV       = 1;
  localparam int          ST_LIVE      = 2;
  localparam int          ST_FOK       = 3;
  localparam int          ST_FAIL      = 7;
  localparam logic [7:0]  ST_WMASK     = 8'h8f;
  localparam logic [7:0]  RST_STATUS   = 8'h00;
  // control bits
  localparam int          CT_LEGACY    = 0;
  localparam int          CT_MUTE      = 1;
  // feature bits
  localparam int          FT_NDATA     = 0;
  localparam int          FT_PACKED    = 1;
  // notification word layout
  localparam int          NF_Q_LSB     = 0;
  localparam int          NF_Q_W       = 16;
  localparam int          NF_OFF_LSB   = 16;
  localparam int          NF_OFF_W     = 15;
  localparam int          NF_WRAP      = 31;
  // random identifier layout
  localparam int          UU_VER_LSB   = 76;
  localparam int          UU_VAR_LSB   = 62;
  localparam logic [3:0]  UU_VER       = 4'h4;
  localparam logic [1:0]  UU_VAR       = 2'h2;
  localparam logic [127:0] LFSR_SEED   = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3211;
  // bus answers
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage : vq_ctl_pkg

// ==== vq_ctl_if.sv ====
// internal carrier between register core, status keeper and notify decoder
// assumes all three parties sit on one clock
interface vq_ctl_if;
  logic        st_wr;
  logic [7:0]  st_wdata;
  logic        feat_good;
  logic        legacy;
  logic [7:0]  status;
  logic        dev_rst;
  logic        nt_wr;
  logic [31:0] nt_word;
  logic        ndata;
  logic        packed_ring;
  logic        nt_valid;
  logic [15:0] nt_queue;
  logic [14:0] nt_off;
  logic        nt_wrap;
  logic        nt_data;
  logic        nt_packed;
  logic        nt_repeat;
  modport core (output st_wr, st_wdata, feat_good, legacy, nt_wr, nt_word, ndata, packed_ring,
                input  status, dev_rst, nt_valid, nt_queue, nt_off, nt_wrap, nt_data,
                       nt_packed, nt_repeat);
  modport stat (input  st_wr, st_wdata, feat_good, legacy, output status, dev_rst);
  modport ntf  (input  nt_wr, nt_word, ndata, packed_ring, dev_rst,
                output nt_valid, nt_queue, nt_off, nt_wrap, nt_data, nt_packed, nt_repeat);
endinterface : vq_ctl_if

// ==== vq_status_keeper.sv ====
// device status field: staged init flags and device reset
// assumes write strobes come from the register core on the same clock
module vq_status_keeper
  import vq_ctl_pkg::*;
(
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // carrier
  vq_ctl_if.stat   c
);
  logic [7:0] st_d;
  logic       rst_d;

  always_comb begin
    st_d  = c.status;
    rst_d = 1'b0;
    if (c.st_wr) begin
      if (c.st_wdata == 8'h00) begin
        st_d  = RST_STATUS;
        rst_d = 1'b1;
      end else begin
        st_d = c.status | (c.st_wdata & ST_WMASK);
        // unsupported subset or legacy: acceptance stays as it was
        if (!c.feat_good || c.legacy) begin
          st_d[ST_FOK] = c.status[ST_FOK];
        end
        // a given-up device is never made live
        if (c.status[ST_FAIL] || c.st_wdata[ST_FAIL]) begin
          st_d[ST_LIVE] = c.status[ST_LIVE];
        end
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      c.status  <= RST_STATUS;
      c.dev_rst <= 1'b0;
    end else begin
      c.status  <= st_d;
      c.dev_rst <= rst_d;
    end
  end

  property p_fok_guard;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    c.st_wr && !c.feat_good && !c.status[ST_FOK] |=> !c.status[ST_FOK];
  endproperty
  a_fok_guard: assert property (p_fok_guard) else $error("acceptance set for bad subset");

  property p_dev_reset;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    c.st_wr && (c.st_wdata == 8'h00) |=> (c.status == 8'h00) && c.dev_rst ##1 !c.dev_rst;
  endproperty
  a_dev_reset: assert property (p_dev_reset) else $error("status not cleared by reset");
endmodule : vq_status_keeper

// ==== vq_notify_decoder.sv ====
// decodes available-buffer notification words into queue, offset, wrap
// assumes the register core only forwards notifications it accepted
module vq_notify_decoder
  import vq_ctl_pkg::*;
(
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // carrier
  vq_ctl_if.ntf    c
);
  logic        valid_d;
  logic [15:0] queue_d;
  logic [14:0] off_d;
  logic        wrap_d;
  logic        data_d;
  logic        packed_d;
  logic        repeat_d;
  logic        seen_q;
  logic        seen_d;

  always_comb begin
    valid_d  = c.nt_wr;
    queue_d  = c.nt_queue;
    off_d    = c.nt_off;
    wrap_d   = c.nt_wrap;
    data_d   = c.nt_data;
    packed_d = c.nt_packed;
    repeat_d = 1'b0;
    seen_d   = seen_q && !c.dev_rst;
    if (c.nt_wr) begin
      queue_d  = c.nt_word[NF_Q_LSB +: NF_Q_W];
      data_d   = c.ndata;
      packed_d = c.packed_ring;
      off_d    = 15'h0000;
      wrap_d   = 1'b0;
      if (c.ndata) begin
        // split: low avail index bits and bit 15; packed: slot and wrap counter
        off_d  = c.nt_word[NF_OFF_LSB +: NF_OFF_W];
        wrap_d = c.nt_word[NF_WRAP];
      end
      // nothing new offered: same payload again, accepted and marked
      repeat_d = seen_q && (queue_d == c.nt_queue) && (off_d == c.nt_off)
                 && (wrap_d == c.nt_wrap);
      seen_d   = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      c.nt_valid  <= 1'b0;
      c.nt_queue  <= 16'h0000;
      c.nt_off    <= 15'h0000;
      c.nt_wrap   <= 1'b0;
      c.nt_data   <= 1'b0;
      c.nt_packed <= 1'b0;
      c.nt_repeat <= 1'b0;
      seen_q      <= 1'b0;
    end else begin
      c.nt_valid  <= valid_d;
      c.nt_queue  <= queue_d;
      c.nt_off    <= off_d;
      c.nt_wrap   <= wrap_d;
      c.nt_data   <= data_d;
      c.nt_packed <= packed_d;
      c.nt_repeat <= repeat_d;
      seen_q      <= seen_d;
    end
  end

  property p_bare_notify;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    c.nt_wr && !c.ndata |=> c.nt_valid && c.nt_off == 15'h0000 && !c.nt_wrap && !c.nt_data;
  endproperty
  a_bare_notify: assert property (p_bare_notify) else $error("payload leaked without feature");

  property p_split_index;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    c.nt_wr && c.ndata |=> {c.nt_wrap, c.nt_off} == $past(c.nt_word[31:16]);
  endproperty
  a_split_index: assert property (p_split_index) else $error("offset or wrap misdecoded");

  property p_repeat;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    c.nt_wr && c.ndata && seen_q && c.nt_word[15:0] == c.nt_queue
      && c.nt_word[31:16] == {c.nt_wrap, c.nt_off} |=> c.nt_repeat && c.nt_valid;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat notify not flagged");
endmodule : vq_notify_decoder

// ==== vq_notify_init_ctrl.sv ====
// top: AXI4-Lite register slave, used/available notification paths, status
// assumes USED_DONE_I comes from device logic on CLOCK_I
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
module vq_notify_init_ctrl
  import vq_ctl_pkg::*;
#(
  parameter logic [31:0] DEV_FEATURES = 32'h0000_0003,
  parameter logic [31:0] SHM_SIZE     = 32'h0001_0000
) (
  // clock and reset
  input  wire logic              CLOCK_I,
  input  wire logic              RST_N_I,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] AXI_AWADDR_I,
  input  wire logic              AXI_AWVALID_I,
  output logic                   AXI_AWREADY_O,
  input  wire logic [31:0]       AXI_WDATA_I,
  input  wire logic [3:0]        AXI_WSTRB_I,
  input  wire logic              AXI_WVALID_I,
  output logic                   AXI_WREADY_O,
  output logic [1:0]             AXI_BRESP_O,
  output logic                   AXI_BVALID_O,
  input  wire logic              AXI_BREADY_I,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] AXI_ARADDR_I,
  input  wire logic              AXI_ARVALID_I,
  output logic                   AXI_ARREADY_O,
  output logic [31:0]            AXI_RDATA_O,
  output logic [1:0]             AXI_RRESP_O,
  output logic                   AXI_RVALID_O,
  input  wire logic              AXI_RREADY_I,
  // used-buffer path
  input  wire logic              USED_DONE_I,
  output logic                   USED_NOTIFY_O,
  // available-buffer notification
  output logic                   NOTIFY_VALID_O,
  output logic [15:0]            NOTIFY_QUEUE_O,
  output logic [14:0]            NOTIFY_OFF_O,
  output logic                   NOTIFY_WRAP_O,
  output logic                   NOTIFY_DATA_O,
  output logic                   NOTIFY_PACKED_O,
  output logic                   NOTIFY_REPEAT_O,
  // device state
  output logic                   LIVE_O,
  output logic                   DEV_RESET_O,
  output logic [31:0]            CFG_O,
  output logic [31:0]            SHM_OFF_O,
  output logic                   SHM_OFF_OK_O
);
  vq_ctl_if c ();

  logic              aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic              aw_rdy_q, aw_rdy_d, w_rdy_q, w_rdy_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0]       wdata_q, wdata_d;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d, ar_rdy_q, ar_rdy_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d, rd_word;
  logic              rd_ok, do_wr, wr_ok;
  logic [1:0]        ctrl_q, ctrl_d;
  logic [31:0]       drv_feat_q, drv_feat_d, cfg_q, cfg_d, shm_q, shm_d;
  logic [31:0]       drops_q, drops_d;
  logic [127:0]      uuid_q, uuid_d, lfsr_q, lfsr_d;
  logic              used_q, used_d, shm_ok_q, shm_ok_d;
  logic              live, legacy;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return a == off;
  endfunction : wr_hit

  vq_status_keeper u_status (
    .CLOCK_I (CLOCK_I),
    .RST_N_I (RST_N_I),
    .c       (c.stat)
  );

  vq_notify_decoder u_notify (
    .CLOCK_I (CLOCK_I),
    .RST_N_I (RST_N_I),
    .c       (c.ntf)
  );

  assign live   = c.status[ST_LIVE];
  assign legacy = ctrl_q[CT_LEGACY];
  assign do_wr  = aw_full_q && w_full_q && !bvalid_q;

  always_comb begin
    wr_ok = 1'b1;
    unique case (awaddr_q)
      OFF_STATUS, OFF_DRV_FEAT, OFF_CTRL, OFF_NOTIFY, OFF_CFG, OFF_SHM, OFF_EXPORT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (AXI_ARADDR_I)
      OFF_STATUS:   rd_word = {24'h00_0000, c.status};
      OFF_DEV_FEAT: rd_word = DEV_FEATURES;
      OFF_DRV_FEAT: rd_word = drv_feat_q;
      OFF_CTRL:     rd_word = {30'h0, ctrl_q};
      OFF_CFG:      rd_word = cfg_q;
      OFF_SHM:      rd_word = shm_q;
      OFF_UUID0:    rd_word = uuid_q[31:0];
      OFF_UUID1:    rd_word = uuid_q[63:32];
      OFF_UUID2:    rd_word = uuid_q[95:64];
      OFF_UUID3:    rd_word = uuid_q[127:96];
      OFF_DROPS:    rd_word = drops_q;
      default:      rd_ok   = 1'b0;
    endcase
  end

  // bus handshake group
  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (AXI_AWVALID_I && aw_rdy_q) begin
      aw_full_d = 1'b1;
      awaddr_d  = AXI_AWADDR_I;
    end
    if (AXI_WVALID_I && w_rdy_q) begin
      w_full_d = 1'b1;
      wdata_d  = AXI_WDATA_I;
      wstrb_d  = AXI_WSTRB_I;
    end
    if (AXI_BREADY_I && bvalid_q) begin
      bvalid_d = 1'b0;
    end
    if (do_wr) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (AXI_RREADY_I && rvalid_q) begin
      rvalid_d = 1'b0;
    end
    if (AXI_ARVALID_I && ar_rdy_q) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_word;
      rresp_d  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    aw_rdy_d = !aw_full_d;
    w_rdy_d  = !w_full_d;
    ar_rdy_d = !rvalid_d;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_rdy_q  <= 1'b1;
      w_rdy_q   <= 1'b1;
      ar_rdy_q  <= 1'b1;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      aw_rdy_q  <= aw_rdy_d;
      w_rdy_q   <= w_rdy_d;
      ar_rdy_q  <= ar_rdy_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // register group
  always_comb begin
    c.st_wr       = do_wr && wr_hit(awaddr_q, OFF_STATUS);
    c.st_wdata    = wdata_q[7:0];
    c.feat_good   = (drv_feat_q & ~DEV_FEATURES) == 32'h0000_0000;
    c.legacy      = legacy;
    c.ndata       = drv_feat_q[FT_NDATA];
    c.packed_ring = drv_feat_q[FT_PACKED];
    c.nt_word     = wdata_q;
    // modern queues stay dead until live; legacy may use them early
    c.nt_wr       = do_wr && wr_hit(awaddr_q, OFF_NOTIFY) && (live || legacy);
    ctrl_d        = ctrl_q;
    drv_feat_d    = drv_feat_q;
    cfg_d         = cfg_q;
    shm_d         = shm_q;
    uuid_d        = uuid_q;
    drops_d       = drops_q;
    lfsr_d        = {lfsr_q[126:0], lfsr_q[127] ^ lfsr_q[125] ^ lfsr_q[100] ^ lfsr_q[98]};
    if (do_wr && wr_hit(awaddr_q, OFF_CTRL)) begin
      ctrl_d = 2'(merge({30'h0, ctrl_q}, wdata_q, wstrb_q));
    end
    // feature set frozen once accepted
    if (do_wr && wr_hit(awaddr_q, OFF_DRV_FEAT) && !c.status[ST_FOK]) begin
      drv_feat_d = merge(drv_feat_q, wdata_q, wstrb_q);
    end
    // modern drivers only write config after acceptance
    if (do_wr && wr_hit(awaddr_q, OFF_CFG) && (legacy || c.status[ST_FOK])) begin
      cfg_d = merge(cfg_q, wdata_q, wstrb_q);
    end
    // region is addressed relative to its start, never absolute
    if (do_wr && wr_hit(awaddr_q, OFF_SHM)) begin
      shm_d = merge(shm_q, wdata_q, wstrb_q);
    end
    if (do_wr && wr_hit(awaddr_q, OFF_EXPORT)) begin
      uuid_d = lfsr_q;
      uuid_d[UU_VER_LSB +: 4] = UU_VER;
      uuid_d[UU_VAR_LSB +: 2] = UU_VAR;
    end
    if (do_wr && wr_hit(awaddr_q, OFF_NOTIFY) && !(live || legacy)) begin
      drops_d = drops_q + 32'h0000_0001;
    end
    if (c.dev_rst) begin
      drv_feat_d = 32'h0000_0000;
      shm_d      = 32'h0000_0000;
    end
    // one data-cache region only; offsets past its size are flagged
    shm_ok_d = shm_q < SHM_SIZE;
    used_d   = USED_DONE_I && live && !ctrl_q[CT_MUTE];
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      ctrl_q     <= 2'h0;
      drv_feat_q <= 32'h0000_0000;
      cfg_q      <= 32'h0000_0000;
      shm_q      <= 32'h0000_0000;
      uuid_q     <= 128'h0;
      lfsr_q     <= LFSR_SEED;
      drops_q    <= 32'h0000_0000;
      used_q     <= 1'b0;
      shm_ok_q   <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      drv_feat_q <= drv_feat_d;
      cfg_q      <= cfg_d;
      shm_q      <= shm_d;
      uuid_q     <= uuid_d;
      lfsr_q     <= lfsr_d;
      drops_q    <= drops_d;
      used_q     <= used_d;
      shm_ok_q   <= shm_ok_d;
    end
  end

  assign AXI_AWREADY_O   = aw_rdy_q;
  assign AXI_WREADY_O    = w_rdy_q;
  assign AXI_BVALID_O    = bvalid_q;
  assign AXI_BRESP_O     = bresp_q;
  assign AXI_ARREADY_O   = ar_rdy_q;
  assign AXI_RVALID_O    = rvalid_q;
  assign AXI_RDATA_O     = rdata_q;
  assign AXI_RRESP_O     = rresp_q;
  assign USED_NOTIFY_O   = used_q;
  assign NOTIFY_VALID_O  = c.nt_valid;
  assign NOTIFY_QUEUE_O  = c.nt_queue;
  assign NOTIFY_OFF_O    = c.nt_off;
  assign NOTIFY_WRAP_O   = c.nt_wrap;
  assign NOTIFY_DATA_O   = c.nt_data;
  assign NOTIFY_PACKED_O = c.nt_packed;
  assign NOTIFY_REPEAT_O = c.nt_repeat;
  assign LIVE_O          = c.status[ST_LIVE];
  assign DEV_RESET_O     = c.dev_rst;
  assign CFG_O           = cfg_q;
  assign SHM_OFF_O       = shm_q;
  assign SHM_OFF_OK_O    = shm_ok_q;

  property p_used_notify;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    USED_DONE_I && LIVE_O && !ctrl_q[CT_MUTE] |=> USED_NOTIFY_O;
  endproperty
  a_used_notify: assert property (p_used_notify) else $error("used notify missing");

  property p_used_muted;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    USED_NOTIFY_O |-> $past(USED_DONE_I) && !$past(ctrl_q[CT_MUTE]);
  endproperty
  a_used_muted: assert property (p_used_muted) else $error("notify while muted");

  property p_not_live_drop;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    do_wr && awaddr_q == OFF_NOTIFY && !LIVE_O && !legacy |=> !NOTIFY_VALID_O;
  endproperty
  a_not_live_drop: assert property (p_not_live_drop) else $error("notify before live");

  property p_legacy_use;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    do_wr && awaddr_q == OFF_NOTIFY && legacy |=> NOTIFY_VALID_O;
  endproperty
  a_legacy_use: assert property (p_legacy_use) else $error("legacy notify refused");

  property p_feat_frozen;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    c.status[ST_FOK] && !c.dev_rst |=> $stable(drv_feat_q);
  endproperty
  a_feat_frozen: assert property (p_feat_frozen) else $error("features changed after accept");

  property p_cfg_guard;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !legacy && !c.status[ST_FOK] |=> $stable(cfg_q);
  endproperty
  a_cfg_guard: assert property (p_cfg_guard) else $error("config written early");

  property p_uuid_version;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    do_wr && awaddr_q == OFF_EXPORT |=> uuid_q[79:76] == 4'h4 && uuid_q[63:62] == 2'h2;
  endproperty
  a_uuid_version: assert property (p_uuid_version) else $error("identifier not version 4");

  property p_reset_not_live;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    DEV_RESET_O |-> !LIVE_O ##1 (!LIVE_O && drv_feat_q == 32'h0000_0000);
  endproperty
  a_reset_not_live: assert property (p_reset_not_live) else $error("live after reset");

  property p_bus_answer;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    AXI_ARVALID_I && AXI_ARREADY_O |=> AXI_RVALID_O;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("read answer late");
endmodule : vq_notify_init_ctrl

// ==== vq_drv_model.sv ====
// driver-side model: register bus master for the slave
// assumes tasks are called just after a rising edge
module vq_drv_model (
  // clock
  input  wire logic        clk_i,
  // write channels
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  // read channels
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
  initial {araddr_o, arvalid_o, rready_o} = '0;
  // driver's view of the used ring
  logic used_wrap = 1'b1;
  int   next_used = 0;
  function automatic logic consumed(input logic offered_flag_bit, input logic consumed_flag_bit);
    return (offered_flag_bit == used_wrap) && (consumed_flag_bit == used_wrap);
  endfunction : consumed
  task automatic reclaim(input int chain, input int qsize);
    next_used += chain;
    if (next_used >= qsize) begin
      next_used -= qsize;
      used_wrap = ~used_wrap;
    end
  endtask : reclaim
  // released payload shows the inverse, not a stale copy
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= 4'hf;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
      if (bvalid_i) break;
    end
    r = bresp_i;
    bready_o <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
      end
      if (rvalid_i) break;
    end
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask : rd
endmodule : vq_drv_model

// ==== tb.sv ====
// bench for the notification and init-status block
// assumes the driver model speaks the register bus
module tb
  import vq_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CK(n,e,s) begin cmp_count++; if ((s) !== (e)) begin errors++; \
  $display("Error %s exp %h got %h", n, e, s); end end
  logic clk = 1'b0, rst_n = 1'b0, used = 1'b0;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd, cfg, shm, wd_x;
  logic [3:0] ws;
  logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [1:0] bp, rp;
  logic nv, nd, np, nr, nw, un, live, sok, dr;
  logic [15:0] nq;
  logic [14:0] no;
  int errors = 0, cmp_count = 0, cyc = 0, nvc = 0, unc = 0, nrc = 0, drc = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    nvc += (nv === 1'b1);
    unc += (un === 1'b1);
    nrc += (nr === 1'b1);
    drc += (dr === 1'b1);
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  vq_drv_model DRV (.clk_i(clk), .awaddr_o(awa), .awvalid_o(awv), .awready_i(awr),
    .wdata_o(wd), .wstrb_o(ws), .wvalid_o(wv), .wready_i(wr), .bresp_i(bp), .bvalid_i(bv),
    .bready_o(br), .araddr_o(ara), .arvalid_o(arv), .arready_i(arr), .rdata_i(rd),
    .rresp_i(rp), .rvalid_i(rv), .rready_o(rr));
  vq_notify_init_ctrl DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .AXI_AWADDR_I(awa),
    .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr), .AXI_WDATA_I(wd), .AXI_WSTRB_I(ws),
    .AXI_WVALID_I(wv), .AXI_WREADY_O(wr), .AXI_BRESP_O(bp), .AXI_BVALID_O(bv),
    .AXI_BREADY_I(br), .AXI_ARADDR_I(ara), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr),
    .AXI_RDATA_O(rd), .AXI_RRESP_O(rp), .AXI_RVALID_O(rv), .AXI_RREADY_I(rr),
    .USED_DONE_I(used), .USED_NOTIFY_O(un), .NOTIFY_VALID_O(nv), .NOTIFY_QUEUE_O(nq),
    .NOTIFY_OFF_O(no), .NOTIFY_WRAP_O(nw), .NOTIFY_DATA_O(nd), .NOTIFY_PACKED_O(np),
    .NOTIFY_REPEAT_O(nr), .LIVE_O(live), .DEV_RESET_O(dr), .CFG_O(cfg), .SHM_OFF_O(shm),
    .SHM_OFF_OK_O(sok));
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] p;
    DRV.wr(a, d, p);
  endtask : w
  task automatic rc(input logic [7:0] a, input logic [31:0] e, output logic [1:0] p);
    logic [31:0] d;
    DRV.rd(a, d, p);
    `CK("rdata", e, d)
  endtask : rc
  task automatic pulse_used();
    @(posedge clk) used <= 1'b1;
    @(posedge clk) used <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse_used
  task automatic t_init();
    logic [1:0] p;
    rc(OFF_STATUS, 32'h0, p);
    rc(8'h40, 32'h0, p);
    `CK("unmapped", RESP_SLVERR, p)
    w(OFF_STATUS, 32'h01);
    w(OFF_STATUS, 32'h02);
    w(OFF_DRV_FEAT, 32'h1);
    rc(OFF_CFG, 32'h0, p);
    w(OFF_STATUS, 32'h08);
    rc(OFF_STATUS, 32'h0b, p);
    // early notify must be dropped and counted
    w(OFF_NOTIFY, 32'h0);
    rc(OFF_DROPS, 32'h1, p);
    w(OFF_STATUS, 32'h04);
    `CK("live", 1'b1, live)
    w(OFF_NOTIFY, 32'hd234_0005);
    w(OFF_NOTIFY, 32'hd234_0005);
    rc(OFF_DROPS, 32'h1, p);
    `CK("notes", 2, nvc)
    `CK("queue", 16'h0005, nq)
    `CK("off", 15'h5234, no)
    `CK("wrap", 1'b1, nw)
    `CK("repeat", 1, nrc)
    `CK("data", 1'b1, nd)
    pulse_used();
    `CK("used", 1, unc)
    w(OFF_CTRL, 32'h2);
    pulse_used();
    `CK("muted", 1, unc)
    DRV.reclaim(3, 4);
    DRV.reclaim(2, 4);
    `CK("used wrap", 1'b0, DRV.used_wrap)
    `CK("consumed", 1'b1, DRV.consumed(1'b0, 1'b0))
    $display("t_init done");
  endtask : t_init
  task automatic t_packed();
    logic [1:0] p;
    w(OFF_STATUS, 32'h0);
    `CK("live", 1'b0, live)
    rc(OFF_STATUS, 32'h0, p);
    w(OFF_STATUS, 32'h80);
    w(OFF_STATUS, 32'h04);
    rc(OFF_STATUS, 32'h80, p);
    w(OFF_STATUS, 32'h0);
    w(OFF_DRV_FEAT, 32'h4);
    w(OFF_STATUS, 32'h08);
    rc(OFF_STATUS, 32'h0, p);
    w(OFF_DRV_FEAT, 32'h2);
    w(OFF_STATUS, 32'h0c);
    w(OFF_DRV_FEAT, 32'h1);
    rc(OFF_DRV_FEAT, 32'h2, p);
    w(OFF_NOTIFY, 32'hffff_0007);
    rc(OFF_STATUS, 32'h0c, p);
    `CK("queue", 16'h0007, nq)
    `CK("off", 15'h0, no)
    `CK("packed", 1'b1, np)
    $display("t_packed done");
  endtask : t_packed
  task automatic t_legacy();
    logic [1:0] p;
    w(OFF_STATUS, 32'h0);
    w(OFF_CTRL, 32'h1);
    w(OFF_CFG, 32'hcafe_0001);
    `CK("cfg", 32'hcafe_0001, cfg)
    w(OFF_DRV_FEAT, 32'h3);
    w(OFF_NOTIFY, 32'h8009_0003);
    rc(OFF_DROPS, 32'h1, p);
    `CK("notes", 4, nvc)
    `CK("off", 15'h0009, no)
    `CK("wrap", 1'b1, nw)
    w(OFF_SHM, 32'h100);
    @(posedge clk);
    `CK("shm", 32'h100, shm)
    `CK("shm ok", 1'b1, sok)
    w(OFF_SHM, 32'h10000);
    @(posedge clk);
    `CK("shm ok", 1'b0, sok)
    w(OFF_EXPORT, 32'h1);
    DRV.rd(OFF_UUID2, wd_x, p);
    `CK("version", 4'h4, wd_x[15:12])
    DRV.rd(OFF_UUID1, wd_x, p);
    `CK("variant", 2'h2, wd_x[31:30])
    `CK("resets", 3, drc)
    $display("t_legacy done");
  endtask : t_legacy
  task automatic close_out();
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_init();
    t_packed();
    t_legacy();
    close_out();
  end
endmodule : tb
